/* File: inc/sram_port_pkg.sv */
package sram_port_pkg;

  // data width of the widest organisation, address width of the narrowest
  localparam int DATA_W = 36;
  localparam int ADDR_W = 21;
  localparam int ADDR_W_X8 = 21;
  localparam int ADDR_W_X9 = 21;
  localparam int ADDR_W_X18 = 20;
  localparam int ADDR_W_X36 = 19;
  localparam int ARRAY_COUNT = 4;

  // write lanes
  localparam int BYTE_LANES = 4;
  localparam int LANE_W = 9;
  localparam int NIBBLE_LANES = 2;
  localparam int NIBBLE_W = 4;

  // burst and storage
  localparam int BURST_LEN = 4;
  localparam int BEAT_IDX_W = 2;
  localparam int MEM_IDX_W = 4;
  localparam int MEM_WORDS = 16;
  localparam int GRP_W = MEM_IDX_W - BEAT_IDX_W;
  localparam int FIFO_DEPTH = 4;

  // beat phase: one input clock cycle is four ref_clk cycles
  localparam logic [1:0] PH_RESET = 2'h0;
  localparam logic [1:0] PH_STEP = 2'h1;
  localparam logic [1:0] PH_K_SAMPLE = 2'h1;
  localparam logic [1:0] PH_KN_SAMPLE = 2'h3;

  // read latency in input clock cycles
  localparam logic [1:0] LAT_PLL = 2'h2;
  localparam logic [1:0] LAT_LEGACY = 2'h1;
  localparam logic [1:0] LAT_LAST = 2'h1;

  // clock figures
  localparam int CLK_PERIOD_NS = 100;
  localparam int LEGACY_MAX_MHZ = 167;

  // reset values
  localparam logic ECHO_RESET = 1'h1;
  localparam logic [DATA_W-1:0] DATA_RESET = 36'h0;

  typedef struct packed {
    logic org_x8;
    logic pll_disable_n;
    logic write_port_sel_n;
    logic read_port_sel_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [BYTE_LANES-1:0] byte_write_sel_n;
    logic [NIBBLE_LANES-1:0] nibble_write_sel_n;
  } pin_in_s;

  typedef struct packed {
    logic [MEM_IDX_W-1:0] idx;
    logic [DATA_W-1:0] mask;
    logic [DATA_W-1:0] data;
  } wr_beat_s;

  typedef enum logic [1:0] {
    RD_IDLE = 2'h0,
    RD_WAIT = 2'h1,
    RD_BURST = 2'h3
  } rd_state_e;

  typedef enum logic {
    WR_IDLE = 1'h0,
    WR_BURST = 1'h1
  } wr_state_e;

endpackage

/* File: verilog/quad_sram_port.sv */
`timescale 1ns/1ps
`default_nettype none

module beat_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  // state
  output logic empty
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] store_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = count_reg != CNT_FULL;
  assign out_valid = count_reg != '0;
  assign empty = count_reg == '0;
  assign out_data = store_reg[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      store_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + PTR_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= '0;
    end else if (push && !pop) begin
      count_reg <= count_reg + CNT_W'(1);
    end else if (pop && !push) begin
      count_reg <= count_reg - CNT_W'(1);
    end
  end

endmodule

module quad_sram_port
  import sram_port_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // controller pins
  input wire pin_in_s pin_in,
  // read data pins
  output logic [DATA_W-1:0] read_data_out,
  output logic read_data_oe,
  output logic read_valid_out,
  // echo clocks
  output logic echo_clk_out,
  output logic echo_clk_n_out
);

  localparam int PIN_W = $bits(pin_in_s);
  localparam int BEAT_W = $bits(wr_beat_s);

  // enable bits of the stored word that one write beat may change
  function automatic logic [DATA_W-1:0] write_mask(
    input logic x8,
    input logic [BYTE_LANES-1:0] byte_sel_n,
    input logic [NIBBLE_LANES-1:0] nib_sel_n
  );
    logic [DATA_W-1:0] m;
    m = '0;
    if (x8) begin
      for (int n = 0; n < NIBBLE_LANES; n++) begin
        m[n*NIBBLE_W +: NIBBLE_W] = {NIBBLE_W{~nib_sel_n[n]}};
      end
    end else begin
      for (int b = 0; b < BYTE_LANES; b++) begin
        m[b*LANE_W +: LANE_W] = {LANE_W{~byte_sel_n[b]}};
      end
    end
    return m;
  endfunction

  pin_in_s sync1_reg;
  pin_in_s sync2_reg;
  pin_in_s sync3_reg;
  pin_in_s pin_f_reg;
  logic [PIN_W-1:0] agree;

  logic [1:0] ph_reg;
  logic [1:0] ph_next;
  logic k_beat;
  logic kn_beat;
  logic any_beat;

  wr_state_e wr_state_reg;
  logic [BEAT_IDX_W-1:0] wr_beat_reg;
  logic [GRP_W-1:0] wr_grp_reg;
  logic wr_start;
  wr_beat_s push_beat;
  wr_beat_s pop_beat;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic fifo_empty;
  logic [BEAT_W-1:0] pop_bits;
  logic pop;

  rd_state_e rd_state_reg;
  logic [1:0] rd_wait_reg;
  logic [BEAT_IDX_W-1:0] rd_beat_reg;
  logic [GRP_W-1:0] rd_grp_reg;
  logic rd_load;
  logic rd_end;
  logic [MEM_IDX_W-1:0] rd_idx;

  logic [DATA_W-1:0] mem_reg [MEM_WORDS];

  // pins: three stages, a bit moves on once stages two and three agree
  assign agree = ~(sync2_reg ^ sync3_reg);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
      sync3_reg <= '1;
      pin_f_reg <= '1;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_f_reg <= pin_in_s'((sync3_reg & agree) | (pin_f_reg & ~agree));
    end
  end

  // beat phase: 0-1 true clock half, 2-3 complementary half
  assign ph_next = ph_reg + PH_STEP;
  assign k_beat = ph_reg == PH_K_SAMPLE;
  assign kn_beat = ph_reg == PH_KN_SAMPLE;
  assign any_beat = k_beat | kn_beat;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ph_reg <= PH_RESET;
    end else begin
      ph_reg <= ph_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      echo_clk_out <= ECHO_RESET;
      echo_clk_n_out <= ~ECHO_RESET;
    end else begin
      echo_clk_out <= ~ph_next[1];
      echo_clk_n_out <= ph_next[1];
    end
  end

  // write port: command at a true beat carries word 0, three beats follow
  assign wr_start = (wr_state_reg == WR_IDLE) && k_beat && !pin_f_reg.write_port_sel_n
                    && fifo_empty && fifo_in_ready;
  assign fifo_in_valid = wr_start || ((wr_state_reg == WR_BURST) && any_beat);

  always_comb begin
    push_beat.data = pin_f_reg.wdata;
    push_beat.mask = write_mask(pin_f_reg.org_x8, pin_f_reg.byte_write_sel_n,
                                pin_f_reg.nibble_write_sel_n);
    if (wr_start) begin
      push_beat.idx = {pin_f_reg.addr[GRP_W-1:0], BEAT_IDX_W'(0)};
    end else begin
      push_beat.idx = {wr_grp_reg, wr_beat_reg};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_state_reg <= WR_IDLE;
      wr_beat_reg <= '0;
      wr_grp_reg <= '0;
    end else begin
      case (wr_state_reg)
        WR_IDLE: begin
          if (wr_start) begin
            wr_grp_reg <= pin_f_reg.addr[GRP_W-1:0];
            wr_beat_reg <= BEAT_IDX_W'(1);
            wr_state_reg <= WR_BURST;
          end
        end
        WR_BURST: begin
          if (any_beat) begin
            wr_beat_reg <= wr_beat_reg + BEAT_IDX_W'(1);
            if (wr_beat_reg == BEAT_IDX_W'(BURST_LEN - 1)) begin
              wr_state_reg <= WR_IDLE;
            end
          end
        end
        default: begin
          wr_state_reg <= WR_IDLE;
        end
      endcase
    end
  end

  beat_fifo #(
    .WIDTH(BEAT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_beat_fifo (
    .clk(ref_clk),
    .rst(sys_rst),
    .in_data(push_beat),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(pop_bits),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .empty(fifo_empty)
  );

  // array write yields to a read access in the same cycle
  assign pop_beat = wr_beat_s'(pop_bits);
  assign fifo_out_ready = !rd_load;
  assign pop = fifo_out_valid && fifo_out_ready;

  genvar w;
  generate
    for (w = 0; w < MEM_WORDS; w++) begin : g_word
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          mem_reg[w] <= DATA_RESET;
        end else if (pop && (pop_beat.idx == MEM_IDX_W'(w))) begin
          mem_reg[w] <= (mem_reg[w] & ~pop_beat.mask) | (pop_beat.data & pop_beat.mask);
        end
      end
    end
  endgenerate

  // read port
  assign rd_idx = {rd_grp_reg, rd_beat_reg};
  assign rd_load = ((rd_state_reg == RD_WAIT) && kn_beat && (rd_wait_reg == LAT_LAST))
                   || ((rd_state_reg == RD_BURST) && any_beat && (rd_beat_reg != '0));
  assign rd_end = (rd_state_reg == RD_BURST) && any_beat && (rd_beat_reg == '0);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_state_reg <= RD_IDLE;
      rd_wait_reg <= '0;
      rd_beat_reg <= '0;
      rd_grp_reg <= '0;
    end else begin
      case (rd_state_reg)
        RD_IDLE: begin
          if (k_beat && !pin_f_reg.read_port_sel_n) begin
            rd_grp_reg <= pin_f_reg.addr[GRP_W-1:0];
            rd_wait_reg <= pin_f_reg.pll_disable_n ? LAT_PLL : LAT_LEGACY;
            rd_beat_reg <= '0;
            rd_state_reg <= RD_WAIT;
          end
        end
        RD_WAIT: begin
          if (rd_load) begin
            rd_beat_reg <= rd_beat_reg + BEAT_IDX_W'(1);
            rd_state_reg <= RD_BURST;
          end else if (kn_beat) begin
            rd_wait_reg <= rd_wait_reg - 2'h1;
          end
        end
        RD_BURST: begin
          if (rd_load) begin
            rd_beat_reg <= rd_beat_reg + BEAT_IDX_W'(1);
          end else if (rd_end) begin
            rd_state_reg <= RD_IDLE;
          end
        end
        default: begin
          rd_state_reg <= RD_IDLE;
        end
      endcase
    end
  end

  // drivers and valid move together on echo clock edges
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      read_data_out <= DATA_RESET;
      read_data_oe <= 1'b0;
      read_valid_out <= 1'b0;
    end else if (rd_load) begin
      read_data_out <= mem_reg[rd_idx];
      read_data_oe <= 1'b1;
      read_valid_out <= 1'b1;
    end else if (rd_end) begin
      read_data_oe <= 1'b0;
      read_valid_out <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* File: sim/sram_port_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module sram_port_chk
  import sram_port_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // pins
  input wire pin_in_s pin_in,
  input wire logic [DATA_W-1:0] read_data_out,
  input wire logic read_data_oe,
  input wire logic read_valid_out,
  input wire logic echo_clk_out,
  input wire logic echo_clk_n_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // cycles since the read select was last low, saturating
  logic [3:0] gap_reg;
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !pin_in.read_port_sel_n) begin
      gap_reg <= 4'h0;
    end else if (gap_reg != 4'hF) begin
      gap_reg <= gap_reg + 4'h1;
    end
  end
  sequence rd_cmd;
    $fell(pin_in.read_port_sel_n) && $rose(echo_clk_out) && gap_reg == 4'hF && !read_data_oe;
  endsequence
  sequence burst;
    read_valid_out [*8] ##1 !read_valid_out;
  endsequence
  reset_idle_a: assert property (disable iff (1'b0) sys_rst |=> !read_data_oe && echo_clk_out)
    else $error("outputs not idle after reset");
  valid_oe_a: assert property (read_valid_out == read_data_oe)
    else $error("valid differs from enable");
  echo_comp_a: assert property (echo_clk_n_out != echo_clk_out)
    else $error("echo pair not complementary");
  echo_period_a: assert property ($rose(echo_clk_out) |=> echo_clk_out ##1 !echo_clk_out [*2] ##1 echo_clk_out)
    else $error("echo period wrong");
  valid_edge_a: assert property ($changed(read_valid_out) |-> $rose(echo_clk_out))
    else $error("valid not echo aligned");
  burst_len_a: assert property ($rose(read_valid_out) |-> burst)
    else $error("burst length wrong");
  word_hold_a: assert property (read_data_oe && echo_clk_out == $past(echo_clk_out) |-> $stable(read_data_out))
    else $error("read word changed within beat");
  read_lat_a: assert property (rd_cmd ##0 pin_in.pll_disable_n |-> ##12 $rose(read_valid_out))
    else $error("read latency wrong");
  legacy_lat_a: assert property (rd_cmd ##0 !pin_in.pll_disable_n |-> ##8 $rose(read_valid_out))
    else $error("legacy read latency wrong");
endmodule
bind quad_sram_port sram_port_chk i_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .pin_in(pin_in),
  .read_data_out(read_data_out), .read_data_oe(read_data_oe), .read_valid_out(read_valid_out),
  .echo_clk_out(echo_clk_out), .echo_clk_n_out(echo_clk_n_out));
`default_nettype wire

/* File: sim/sram_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sram_host
  import sram_port_pkg::*;
(
  // clock and echo
  input wire logic ref_clk,
  input wire logic echo_clk_out,
  // pins
  output var pin_in_s pin_in
);
  initial begin
    pin_in = '1;
    pin_in.org_x8 = 1'b0;
  end
  // wait for the edge that opens a true-clock beat
  task automatic sync();
    logic prev;
    prev = 1'b1;
    forever begin
      @(posedge ref_clk);
      if (!prev && !echo_clk_out) break;
      prev = echo_clk_out;
    end
  endtask
  task automatic mode(input logic x, input logic p);
    pin_in.org_x8 <= x;
    pin_in.pll_disable_n <= p;
  endtask
  // one beat held for an echo half
  task automatic beat(input logic w_n, input logic r_n, input logic [1:0] a, input logic [DATA_W-1:0] d,
    input logic [3:0] b, input logic [1:0] n);
    pin_in.write_port_sel_n <= w_n;
    pin_in.read_port_sel_n <= r_n;
    pin_in.addr <= (w_n && r_n) ? ~pin_in.addr : ADDR_W'(a);
    pin_in.wdata <= d;
    pin_in.byte_write_sel_n <= b;
    pin_in.nibble_write_sel_n <= n;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic idle();
    beat(1'b1, 1'b1, 2'h0, ~pin_in.wdata, ~pin_in.byte_write_sel_n, ~pin_in.nibble_write_sel_n);
  endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
  import sram_port_pkg::*;
;
  typedef struct packed {
    logic x8;
    logic pll_n;
    logic [1:0] grp;
    logic [15:0] byte_n;
    logic [7:0] nib_n;
    logic [4:0] lat;
  } row_s;
  row_s rows [7] = '{'{1'h0, 1'h1, 2'h0, 16'h0000, 8'hFF, 5'hC}, '{1'h0, 1'h1, 2'h1, 16'h0000, 8'hFF, 5'hC},
    '{1'h0, 1'h0, 2'h2, 16'h0000, 8'hFF, 5'h8}, '{1'h0, 1'h0, 2'h3, 16'h0000, 8'hFF, 5'h8},
    '{1'h0, 1'h1, 2'h1, 16'h5A3C, 8'hFF, 5'hC}, '{1'h1, 1'h0, 2'h2, 16'h0000, 8'h93, 5'h8},
    '{1'h1, 1'h1, 2'h0, 16'h0000, 8'h6C, 5'hC}};
  logic ref_clk;
  logic sys_rst;
  pin_in_s pin_in;
  logic [DATA_W-1:0] read_data_out;
  logic read_data_oe, read_valid_out, echo_clk_out, echo_clk_n_out, last_e;
  logic [DATA_W-1:0] mem [MEM_WORDS];
  logic [DATA_W-1:0] got_q [$];
  int cyc_q [$];
  int cyc = 0;
  int err_count = 0;
  int checks = 0;
  int t0;
  quad_sram_port i_quad_sram_port (.ref_clk(ref_clk), .sys_rst(sys_rst), .pin_in(pin_in),
    .read_data_out(read_data_out), .read_data_oe(read_data_oe), .read_valid_out(read_valid_out),
    .echo_clk_out(echo_clk_out), .echo_clk_n_out(echo_clk_n_out));
  sram_host i_sram_host (.ref_clk(ref_clk), .echo_clk_out(echo_clk_out), .pin_in(pin_in));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;
  // collect one word per echo half while valid
  always @(negedge ref_clk) begin
    if (read_valid_out === 1'b1 && echo_clk_out !== last_e) begin
      got_q.push_back(read_data_out);
      cyc_q.push_back(cyc);
    end
    last_e = echo_clk_out;
  end
  function automatic logic [DATA_W-1:0] dat(input int r, input int k);
    return 36'h5_A3C9_6E17 ^ {9{4'(r * 4 + k)}};
  endfunction
  task automatic chk(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask
  task automatic close_out();
    if (err_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // write burst; w2_n low repeats the command mid-burst towards another group
  task automatic wr(input int r, input logic x8, input logic [1:0] g, input logic [15:0] b, input logic [7:0] n,
    input logic w2_n);
    logic [DATA_W-1:0] m;
    for (int k = 0; k < 4; k++) begin
      m = x8 ? {28'h0, {4{~n[2*k+1]}}, {4{~n[2*k]}}}
             : {{9{~b[4*k+3]}}, {9{~b[4*k+2]}}, {9{~b[4*k+1]}}, {9{~b[4*k]}}};
      mem[{g, 2'(k)}] = (mem[{g, 2'(k)}] & ~m) | (dat(r, k) & m);
      i_sram_host.beat(k == 0 ? 1'b0 : (k == 2 ? w2_n : 1'b1), 1'b1, k == 2 ? ~g : g, dat(r, k),
                       b[4*k+:4], n[2*k+:2]);
    end
  endtask
  task automatic rd(input logic [1:0] g);
    t0 = cyc + 1;
    i_sram_host.beat(1'b1, 1'b0, g, ~pin_in.wdata, 4'hF, 2'h3);
    i_sram_host.idle();
  endtask
  task automatic rd_chk(input logic [1:0] g, input logic [4:0] lat);
    repeat (24) @(posedge ref_clk);
    chk("words", 36'h4, 36'(got_q.size()));
    if (got_q.size() == 4) begin
      chk("latency", 36'(lat), 36'(cyc_q[0] - t0));
      for (int k = 0; k < 4; k++) chk("word", mem[{g, 2'(k)}], got_q[k]);
    end
    chk("oe off", 36'h0, 36'(read_data_oe));
    got_q.delete();
    cyc_q.delete();
  endtask
  initial begin
    #1000000;
    err_count++;
    close_out();
  end
  initial begin
    sys_rst = 1'b1;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    chk("echo", 36'h1, 36'(echo_clk_out));
    chk("oe", 36'h0, 36'(read_data_oe));
    i_sram_host.sync();
    foreach (rows[r]) begin
      i_sram_host.mode(rows[r].x8, rows[r].pll_n);
      wr(r, rows[r].x8, rows[r].grp, rows[r].byte_n, rows[r].nib_n, 1'b1);
      repeat (4) i_sram_host.idle();
      rd(rows[r].grp);
      rd_chk(rows[r].grp, rows[r].lat);
    end
    // commands repeated while a burst runs are ignored
    i_sram_host.mode(1'b0, 1'b1);
    wr(7, 1'b0, 2'h3, 16'h0000, 8'hFF, 1'b0);
    repeat (4) i_sram_host.idle();
    rd(2'h0);
    repeat (2) i_sram_host.idle();
    i_sram_host.beat(1'b1, 1'b0, 2'h3, ~pin_in.wdata, 4'hF, 2'h3);
    i_sram_host.idle();
    rd_chk(2'h0, 5'hC);
    rd(2'h3);
    rd_chk(2'h3, 5'hC);
    close_out();
  end
endmodule
`default_nettype wire
